// ---- hcfi_host_fifo.sv ----
/*
 * hcfi_host_fifo: host side of the command/data fifo, the status register
 * and the host read mux, plus the fifo buffer module it uses.
 * assumes host strobes and buses are asynchronous to clk and are held
 * for at least three clk periods; program side signals are on clk.
 */
`timescale 1ns/1ns


// ********************************************************************
// fifo buffer
// ********************************************************************
module hcfi_fifo #(
    parameter int unsigned WIDTH = 22,
    parameter int unsigned DEPTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // flush
    input wire logic flush,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int unsigned PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wr_ptr;
        logic [PW-1:0] rd_ptr;
        logic [PW:0] count;
    } hcfi_fifo_state_t;

    hcfi_fifo_state_t state;
    hcfi_fifo_state_t next_state;
    logic push;
    logic pop;

    // honest flags straight from the occupancy count
    assign in_ready = (state.count != (PW+1)'(DEPTH));
    assign out_valid = (state.count != '0);
    assign out_data = state.mem[state.rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // pointer and count update; flush wins over a same-cycle push or pop
    always_comb begin
        next_state = state;
        if (push) begin
            next_state.mem[state.wr_ptr] = in_data;
            next_state.wr_ptr = state.wr_ptr + 1'b1;
        end
        if (pop) begin
            next_state.rd_ptr = state.rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            next_state.count = state.count + 1'b1;
        end else if (pop && !push) begin
            next_state.count = state.count - 1'b1;
        end
        if (flush) begin
            next_state.wr_ptr = '0;
            next_state.rd_ptr = '0;
            next_state.count = '0;
        end
    end

    // storage register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end
endmodule // hcfi_fifo

// ********************************************************************
// host interface top
// ********************************************************************
module hcfi_host_fifo (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // host pins
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [hcfi_pkg::HCFI_ADDR_W-1:0] host_addr_bus,
    input wire logic [hcfi_pkg::HCFI_DATA_W-1:0] host_data_bus_in,
    output logic [hcfi_pkg::HCFI_DATA_W-1:0] host_data_bus_out,
    output logic host_data_bus_oe,
    // mode
    input wire logic standalone_mode,
    // program side fifo access
    input wire logic fifo_to_register_instr,
    input wire logic jump_call_fifo_instr,
    output logic fifo_cmd_tag_cond,
    output logic fifo_output_ready,
    output logic fifo_input_ready,
    output logic [hcfi_pkg::HCFI_PC_W-1:0] fifo_branch_addr,
    output logic [hcfi_pkg::HCFI_REG_W-1:0] fifo_reg_sel,
    output logic [hcfi_pkg::HCFI_DATA_W-1:0] fifo_data,
    output logic fifo_reg_load,
    output logic fifo_branch_take,
    // data input and output registers
    output logic [hcfi_pkg::HCFI_DATA_W-1:0] data_in_reg,
    input wire logic data_out_load,
    input wire logic [hcfi_pkg::HCFI_DATA_W-1:0] data_out_value,
    // status sources
    input wire logic [hcfi_pkg::HCFI_PC_W-1:0] program_counter,
    input wire logic cpu_flags_update,
    input wire hcfi_pkg::hcfi_cpu_flags_t cpu_flags,
    input wire hcfi_pkg::hcfi_prog_events_t prog_events,
    input wire logic security_active_flag,
    output logic [hcfi_pkg::HCFI_STAT_W-1:0] host_status_flags,
    // interrupt requests and their enables
    input wire logic interrupt_level_five_enable,
    input wire logic interrupt_level_seven_full_enable,
    input wire logic interrupt_level_seven_exc_enable,
    output logic interrupt_level_five,
    output logic interrupt_level_seven
);
    import hcfi_pkg::*;

    typedef struct packed {
        // two-flop synchronisers on each raw pin, then a third stage for edge detect
        logic cs_s1;
        logic cs_s2;
        logic rdp_s1;
        logic rdp_s2;
        logic wrp_s1;
        logic wrp_s2;
        logic wr_s3;
        logic rd_s3;
        logic [HCFI_ADDR_W-1:0] addr_s1;
        logic [HCFI_ADDR_W-1:0] addr_s2;
        logic [HCFI_DATA_W-1:0] data_s1;
        logic [HCFI_DATA_W-1:0] data_s2;
        // host capture
        logic [HCFI_ADDR_W-1:0] cap_addr;
        logic [HCFI_DATA_W-1:0] dir;
        // registers seen by the host
        logic [HCFI_DATA_W-1:0] host_data_out_reg;
        logic [HCFI_DATA_W-1:0] rd_data;
        logic rd_oe;
        // status register storage
        logic fifo_exception;
        hcfi_cpu_flags_t flags;
        hcfi_prog_events_t events;
    } hcfi_state_t;

    hcfi_state_t state;
    hcfi_state_t next_state;

    logic wr_strobe;
    logic rd_strobe;
    logic wr_done;
    logic rd_start;
    logic rd_decodable;
    logic fifo_flush;
    logic stat_clear;
    logic push_valid;
    logic push_ready;
    logic head_valid;
    logic pop;
    logic exc_event;
    hcfi_entry_t push_entry;
    hcfi_entry_t head;
    logic [HCFI_STAT_W-1:0] status_word;

    // ****************************************************************
    // host cycle decode
    // ****************************************************************
    // each pin is synchronised alone first, so skew between pins cannot glitch a strobe
    assign wr_strobe = !state.cs_s2 && !state.wrp_s2 && state.rdp_s2;
    assign rd_strobe = !state.cs_s2 && !state.rdp_s2 && state.wrp_s2;
    assign wr_done = state.wr_s3 && !wr_strobe;
    assign rd_start = rd_strobe && !state.rd_s3;
    assign rd_decodable = !state.addr_s2[HCFI_TAG_BIT];
    // control reads act once per host cycle, at its synchronised start
    assign fifo_flush = rd_start && rd_decodable
        && (state.addr_s2[HCFI_REG_W-1:0] == HCFI_CODE_FIFO_RESET);
    assign stat_clear = rd_start && rd_decodable
        && (state.addr_s2[HCFI_REG_W-1:0] == HCFI_CODE_STAT_RESET);

    // entry built from the address and data held at the write's release
    always_comb begin
        push_entry.is_cmd = state.cap_addr[HCFI_TAG_BIT];
        push_entry.reg_sel = state.cap_addr[HCFI_REG_W-1:0];
        push_entry.data = state.dir;
    end
    // a write while full is dropped; the host is expected to poll input-ready
    assign push_valid = wr_done && !standalone_mode;

    // ****************************************************************
    // fifo and program side
    // ****************************************************************
    hcfi_fifo #(
        .WIDTH(HCFI_ENTRY_W),
        .DEPTH(HCFI_FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .resetn(resetn),
        .flush(fifo_flush),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data(push_entry),
        .out_valid(head_valid),
        .out_ready(pop),
        .out_data(head)
    );

    // either instruction consumes the head; a tag mismatch is an exception
    assign pop = head_valid && (fifo_to_register_instr || jump_call_fifo_instr);
    assign exc_event = head_valid
        && ((fifo_to_register_instr && head.is_cmd)
        || (jump_call_fifo_instr && !head.is_cmd));
    assign fifo_reg_load = head_valid && fifo_to_register_instr && !head.is_cmd;
    assign fifo_branch_take = head_valid && jump_call_fifo_instr && head.is_cmd;
    assign fifo_branch_addr = head.data[HCFI_PC_W-1:0];
    assign fifo_reg_sel = head.reg_sel;
    assign fifo_data = head.data;
    assign fifo_cmd_tag_cond = head_valid && head.is_cmd;
    assign fifo_output_ready = head_valid;
    assign fifo_input_ready = push_ready;
    assign data_in_reg = state.dir;

    // interrupt requests are levels; masking leaves the poll flag intact
    assign interrupt_level_five = interrupt_level_five_enable && head_valid;
    assign interrupt_level_seven = (interrupt_level_seven_full_enable && !push_ready)
        || (interrupt_level_seven_exc_enable && state.fifo_exception);

    // ****************************************************************
    // status register assembly
    // ****************************************************************
    always_comb begin
        status_word = HCFI_STAT_RESET;
        status_word[HCFI_ST_SECURITY] = security_active_flag;
        status_word[HCFI_ST_FIFO_EXCEPTION] = state.fifo_exception;
        status_word[HCFI_ST_INPUT_READY] = push_ready;
        status_word[HCFI_ST_CARRY] = state.flags.carry;
        status_word[HCFI_ST_ZERO] = state.flags.zero;
        status_word[HCFI_ST_OVERFLOW] = state.flags.overflow;
        status_word[HCFI_ST_SIGN] = state.flags.sign;
        status_word[HCFI_ST_STACK_FULL] = state.events.stack_full;
        status_word[HCFI_ST_BREAKPOINT] = state.events.breakpoint;
        status_word[HCFI_ST_BLOCK_ZERO] = state.events.block_zero;
        status_word[HCFI_ST_ADDR_ONES] = state.events.addr_ones;
    end
    assign host_status_flags = status_word;

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        next_state = state;
        // synchronisers
        next_state.cs_s1 = cs_n;
        next_state.cs_s2 = state.cs_s1;
        next_state.rdp_s1 = rd_n;
        next_state.rdp_s2 = state.rdp_s1;
        next_state.wrp_s1 = wr_n;
        next_state.wrp_s2 = state.wrp_s1;
        next_state.wr_s3 = wr_strobe;
        next_state.rd_s3 = rd_strobe;
        next_state.addr_s1 = host_addr_bus;
        next_state.addr_s2 = state.addr_s1;
        next_state.data_s1 = host_data_bus_in;
        next_state.data_s2 = state.data_s1;
        // track bus contents while the write is active; the last sample wins
        if (wr_strobe) begin
            next_state.cap_addr = state.addr_s2;
            next_state.dir = state.data_s2;
        end
        // data output register loaded by the program
        if (data_out_load) begin
            next_state.host_data_out_reg = data_out_value;
        end
        // read mux, refreshed each cycle of an active read
        next_state.rd_oe = rd_strobe && rd_decodable
            && (state.addr_s2[HCFI_REG_W-1:0] <= HCFI_CODE_RD_PC);
        case (state.addr_s2[HCFI_REG_W-1:0])
            HCFI_CODE_RD_PC: begin
                next_state.rd_data = HCFI_DATA_W'(program_counter);
            end
            HCFI_CODE_RD_STATUS: begin
                next_state.rd_data = HCFI_DATA_W'(status_word);
            end
            HCFI_CODE_RD_DATA_OUT: begin
                next_state.rd_data = state.host_data_out_reg;
            end
            default: begin
                next_state.rd_data = '0;
            end
        endcase
        // host clear first, so a same-cycle set from the program wins
        if (stat_clear) begin
            next_state.fifo_exception = 1'b0;
            next_state.flags = '0;
            next_state.events = '0;
        end
        if (exc_event) begin
            next_state.fifo_exception = 1'b1;
        end
        if (cpu_flags_update) begin
            next_state.flags = cpu_flags;
        end
        next_state.events = next_state.events | prog_events;
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    // all status flags but the security bit latch on the rising clock edge
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign host_data_bus_out = state.rd_data;
    assign host_data_bus_oe = state.rd_oe;
endmodule // hcfi_host_fifo

// ---- hcfi_host_fifo_sva.sv ----
/* checker for the host command fifo interface, seeing only the top ports.
   assumes one clock domain and an asynchronous active-low resetn. */
`timescale 1ns/1ns
module hcfi_sva (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // program side
    input wire logic fifo_to_register_instr,
    input wire logic jump_call_fifo_instr,
    input wire logic fifo_cmd_tag_cond,
    input wire logic fifo_output_ready,
    input wire logic fifo_input_ready,
    input wire logic [hcfi_pkg::HCFI_PC_W-1:0] fifo_branch_addr,
    input wire logic [hcfi_pkg::HCFI_DATA_W-1:0] fifo_data,
    input wire logic fifo_reg_load,
    input wire logic fifo_branch_take,
    // status and interrupts
    input wire logic cpu_flags_update,
    input wire hcfi_pkg::hcfi_cpu_flags_t cpu_flags,
    input wire hcfi_pkg::hcfi_prog_events_t prog_events,
    input wire logic [hcfi_pkg::HCFI_STAT_W-1:0] host_status_flags,
    input wire logic interrupt_level_five_enable,
    input wire logic interrupt_level_seven_full_enable,
    input wire logic interrupt_level_seven_exc_enable,
    input wire logic interrupt_level_five,
    input wire logic interrupt_level_seven
);
    import hcfi_pkg::*;
    // ********************
    // assertions
    // ********************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    interrupt_level_five_level_a: assert property (interrupt_level_five == (interrupt_level_five_enable && fifo_output_ready))
        else $error("interrupt_level_five level wrong");
    interrupt_level_five_mask_a: assert property (!interrupt_level_five_enable |-> !interrupt_level_five)
        else $error("masked interrupt_level_five raised");
    branch_take_a: assert property (jump_call_fifo_instr && fifo_cmd_tag_cond |->
        fifo_branch_take && fifo_branch_addr == fifo_data[9:0]) else $error("branch not taken");
    reg_load_a: assert property (fifo_to_register_instr && fifo_output_ready && !fifo_cmd_tag_cond
        |-> fifo_reg_load) else $error("register load missing");
    cmd_exc_a: assert property (fifo_to_register_instr && fifo_cmd_tag_cond |=> host_status_flags[9])
        else $error("exception flag not set");
    interrupt_level_seven_level_a: assert property (interrupt_level_seven == ((interrupt_level_seven_full_enable && !fifo_input_ready)
        || (interrupt_level_seven_exc_enable && host_status_flags[9]))) else $error("interrupt_level_seven level wrong");
    input_stat_a: assert property (host_status_flags[8] == fifo_input_ready)
        else $error("input ready bit wrong");
    cpu_flags_a: assert property (cpu_flags_update |=> host_status_flags[7:4] == $past(cpu_flags))
        else $error("cpu flags not captured");
    event_set_a: assert property (prog_events != 4'h0 |=>
        (host_status_flags[3:0] & $past(prog_events)) == $past(prog_events)) else $error("event not held");
    host_set_a: assert property (!cpu_flags_update && prog_events == 4'h0 && !fifo_to_register_instr
        |=> (host_status_flags[7:0] & ~$past(host_status_flags[7:0])) == 8'h00) else $error("status set idle");
    tag_cond_a: assert property (fifo_cmd_tag_cond |-> fifo_output_ready)
        else $error("tag without entry");
    // main scenarios reached
    cover property (fifo_branch_take);
    cover property (!fifo_input_ready);
    cover property (interrupt_level_seven);
endmodule // hcfi_sva

bind hcfi_host_fifo hcfi_sva sva_u (.clk, .resetn, .fifo_to_register_instr, .jump_call_fifo_instr,
    .fifo_cmd_tag_cond, .fifo_output_ready, .fifo_input_ready, .fifo_branch_addr, .fifo_data,
    .fifo_reg_load, .fifo_branch_take, .cpu_flags_update, .cpu_flags, .prog_events, .host_status_flags,
    .interrupt_level_five_enable, .interrupt_level_seven_full_enable, .interrupt_level_seven_exc_enable, .interrupt_level_five, .interrupt_level_seven);

// ---- hcfi_host_model.sv ----
/* model of the asynchronous host processor on the memory-mapped bus.
   assumes the bench calls its tasks; strobes move just after clk rises. */
`timescale 1ns/1ns
module hcfi_host_model (
    // clock
    input wire logic clk,
    // host pins
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic [hcfi_pkg::HCFI_ADDR_W-1:0] host_addr_bus,
    output logic [hcfi_pkg::HCFI_DATA_W-1:0] data_out,
    // device answers
    input wire logic [hcfi_pkg::HCFI_DATA_W-1:0] data_in,
    input wire logic oe,
    input wire logic input_ready
);
    // ********************
    // bus cycles
    // ********************
    initial begin
        cs_n = 1;
        rd_n = 1;
        wr_n = 1;
        host_addr_bus = '0;
        data_out = '0;
    end
    // strobes held 4 clocks so the device synchroniser sees them whole
    task automatic host_write(input logic [5:0] a, input logic [15:0] d, input logic frc);
        if (!frc && !input_ready) return;
        @(posedge clk);
        cs_n <= 0;
        wr_n <= 0;
        host_addr_bus <= a;
        data_out <= d;
        repeat (4) @(posedge clk);
        cs_n <= 1;
        wr_n <= 1;
        repeat (2) @(posedge clk);
        host_addr_bus <= ~a; // bus released: no stale value left
        data_out <= ~d;
        repeat (5) @(posedge clk);
    endtask
    task automatic host_read(input logic [5:0] a, output logic [15:0] d, output logic o);
        @(posedge clk);
        cs_n <= 0;
        rd_n <= 0;
        host_addr_bus <= a;
        repeat (4) @(posedge clk);
        // answer taken mid-cycle, away from the edge that refreshes it
        @(negedge clk);
        d = data_in;
        o = oe;
        @(posedge clk);
        cs_n <= 1;
        rd_n <= 1;
        repeat (2) @(posedge clk);
        host_addr_bus <= ~a;
        repeat (4) @(posedge clk);
    endtask
endmodule // hcfi_host_model

// ---- hcfi_pkg.sv ----
/*
 * hcfi_pkg: constants and types shared by the host command fifo interface.
 * assumes a single 250 MHz device clock and an asynchronous active-low reset.
 */
package hcfi_pkg;

    // ****************************************************************
    // widths and sizes
    // ****************************************************************
    localparam int unsigned HCFI_DATA_W = 16;
    localparam int unsigned HCFI_ADDR_W = 6;
    localparam int unsigned HCFI_REG_W = 5;
    localparam int unsigned HCFI_PC_W = 10;
    localparam int unsigned HCFI_STAT_W = 12;
    localparam int unsigned HCFI_FIFO_DEPTH = 16;

    // ****************************************************************
    // host address decode
    // ****************************************************************
    localparam int unsigned HCFI_TAG_BIT = 5;
    localparam logic [HCFI_REG_W-1:0] HCFI_CODE_FIFO_RESET = 5'h04;
    localparam logic [HCFI_REG_W-1:0] HCFI_CODE_STAT_RESET = 5'h03;
    localparam logic [HCFI_REG_W-1:0] HCFI_CODE_RD_PC = 5'h02;
    localparam logic [HCFI_REG_W-1:0] HCFI_CODE_RD_STATUS = 5'h01;
    localparam logic [HCFI_REG_W-1:0] HCFI_CODE_RD_DATA_OUT = 5'h00;

    // ****************************************************************
    // status register bit positions
    // ****************************************************************
    localparam int unsigned HCFI_ST_SECURITY = 11;
    localparam int unsigned HCFI_ST_FIFO_EXCEPTION = 9;
    localparam int unsigned HCFI_ST_INPUT_READY = 8;
    localparam int unsigned HCFI_ST_CARRY = 7;
    localparam int unsigned HCFI_ST_ZERO = 6;
    localparam int unsigned HCFI_ST_OVERFLOW = 5;
    localparam int unsigned HCFI_ST_SIGN = 4;
    localparam int unsigned HCFI_ST_STACK_FULL = 3;
    localparam int unsigned HCFI_ST_BREAKPOINT = 2;
    localparam int unsigned HCFI_ST_BLOCK_ZERO = 1;
    localparam int unsigned HCFI_ST_ADDR_ONES = 0;
    localparam logic [HCFI_STAT_W-1:0] HCFI_STAT_RESET = 12'h000;

    // ****************************************************************
    // carriers
    // ****************************************************************
    // one fifo entry: tag high means command
    typedef struct packed {
        logic is_cmd;
        logic [HCFI_REG_W-1:0] reg_sel;
        logic [HCFI_DATA_W-1:0] data;
    } hcfi_entry_t;

    localparam int unsigned HCFI_ENTRY_W = $bits(hcfi_entry_t);

    // cpu result flags, in status order carry, zero, overflow, sign
    typedef struct packed {
        logic carry;
        logic zero;
        logic overflow;
        logic sign;
    } hcfi_cpu_flags_t;

    // event flags raised by program execution
    typedef struct packed {
        logic stack_full;
        logic breakpoint;
        logic block_zero;
        logic addr_ones;
    } hcfi_prog_events_t;

endpackage

// ---- hcfi_tb.sv ----
/* self-checking bench for hcfi_host_fifo with a queue model of the fifo.
   assumes hcfi_host_model drives the host pins; 250 MHz clock. */
`timescale 1ns/1ns
module tb;
    import hcfi_pkg::*;
    // ********************
    // signals and model
    // ********************
    logic clk, resetn, cs_n, rd_n, wr_n, host_data_bus_oe, standalone_mode, fifo_to_register_instr;
    logic jump_call_fifo_instr, fifo_cmd_tag_cond, fifo_output_ready, fifo_input_ready, fifo_reg_load;
    logic fifo_branch_take, data_out_load, cpu_flags_update, security_active_flag, interrupt_level_five_enable;
    logic interrupt_level_seven_full_enable, interrupt_level_seven_exc_enable, interrupt_level_five, interrupt_level_seven;
    logic [HCFI_ADDR_W-1:0] host_addr_bus;
    logic [HCFI_DATA_W-1:0] host_data_bus_in, host_data_bus_out, fifo_data, data_in_reg, data_out_value;
    logic [HCFI_PC_W-1:0] program_counter, fifo_branch_addr;
    logic [HCFI_REG_W-1:0] fifo_reg_sel;
    logic [HCFI_STAT_W-1:0] host_status_flags;
    hcfi_cpu_flags_t cpu_flags;
    hcfi_prog_events_t prog_events;
    logic [21:0] q[$];
    logic [3:0] m_flags, m_ev;
    logic m_exc, rd_oe;
    logic [15:0] rd_v;
    logic [31:0] r;
    int seed = 67168, miscompares = 0, n_tests = 0, i;

    hcfi_host_fifo dut_u (.clk, .resetn, .cs_n, .rd_n, .wr_n, .host_addr_bus, .host_data_bus_in,
        .host_data_bus_out, .host_data_bus_oe, .standalone_mode, .fifo_to_register_instr,
        .jump_call_fifo_instr, .fifo_cmd_tag_cond, .fifo_output_ready, .fifo_input_ready, .fifo_branch_addr,
        .fifo_reg_sel, .fifo_data, .fifo_reg_load, .fifo_branch_take, .data_in_reg, .data_out_load,
        .data_out_value, .program_counter, .cpu_flags_update, .cpu_flags, .prog_events, .security_active_flag,
        .host_status_flags, .interrupt_level_five_enable, .interrupt_level_seven_full_enable, .interrupt_level_seven_exc_enable, .interrupt_level_five,
        .interrupt_level_seven);
    hcfi_host_model host_u (.clk, .cs_n, .rd_n, .wr_n, .host_addr_bus, .data_out(host_data_bus_in),
        .data_in(host_data_bus_out), .oe(host_data_bus_oe), .input_ready(fifo_input_ready));

    // status word as the rules lay it out; bit 10 reads 0
    function automatic logic [11:0] exp_stat();
        return {security_active_flag, 1'b0, m_exc, q.size() < 16, m_flags, m_ev};
    endfunction
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s exp %h got %h", name, exp, got);
        end
    endtask
    task automatic close_out();
        $display("tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // one random host write; the model keeps what the device should accept
    task automatic wr(input logic frc);
        r = $random(seed);
        if (!standalone_mode && q.size() < 16) q.push_back(r[21:0]);
        host_u.host_write(r[21:16], r[15:0], frc);
    endtask
    task automatic hr(input logic [5:0] a);
        host_u.host_read(a, rd_v, rd_oe);
    endtask
    // program pop: jump when jmp is high, register read otherwise
    task automatic pop(input logic jmp);
        logic [21:0] h;
        logic ne;
        ne = q.size() > 0;
        h = ne ? q[0] : 22'h0;
        @(posedge clk);
        fifo_to_register_instr <= !jmp;
        jump_call_fifo_instr <= jmp;
        @(negedge clk);
        chk("take", ne && jmp && h[21], fifo_branch_take);
        chk("load", ne && !jmp && !h[21], fifo_reg_load);
        if (ne) begin
            chk("tag", h[21], fifo_cmd_tag_cond);
            chk("entry", h[20:0], {fifo_reg_sel, fifo_data});
            chk("branch", h[9:0], fifo_branch_addr);
            m_exc = m_exc | (jmp != h[21]);
            void'(q.pop_front());
        end
        @(posedge clk);
        fifo_to_register_instr <= 0;
        jump_call_fifo_instr <= 0;
    endtask

    // ********************
    // sequence
    // ********************
    initial begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    initial begin
        #40000;
        miscompares++;
        close_out();
    end
    initial begin
        {resetn, standalone_mode, fifo_to_register_instr, jump_call_fifo_instr, data_out_load} = '0;
        {cpu_flags_update, security_active_flag, interrupt_level_five_enable, interrupt_level_seven_full_enable, interrupt_level_seven_exc_enable} = '0;
        {data_out_value, program_counter, cpu_flags, prog_events, m_flags, m_ev, m_exc} = '0;
        repeat (3) @(posedge clk);
        resetn <= 1;
        @(negedge clk);
        chk("ready", 2'b01, {fifo_output_ready, fifo_input_ready});
        chk("status", exp_stat(), host_status_flags);
        // fill to full, then a write the device must drop
        for (i = 0; i < 16; i++) begin
            wr(0);
            if (i == 0) chk("din", r[15:0], data_in_reg);
        end
        wr(1);
        @(posedge clk);
        interrupt_level_five_enable <= 1;
        interrupt_level_seven_full_enable <= 1;
        @(negedge clk);
        chk("full", exp_stat(), host_status_flags);
        chk("irq", 2'b11, {interrupt_level_five, interrupt_level_seven});
        @(posedge clk);
        interrupt_level_five_enable <= 0;
        interrupt_level_seven_full_enable <= 0;
        interrupt_level_seven_exc_enable <= 1;
        @(negedge clk);
        chk("poll", 2'b10, {fifo_output_ready, interrupt_level_five});
        // drain with random instruction kinds, one pop past empty
        for (i = 0; i < 17; i++) begin
            r = $random(seed);
            pop(r[0]);
        end
        @(negedge clk);
        chk("exc_irq", m_exc, interrupt_level_seven);
        chk("status", exp_stat(), host_status_flags);
        @(posedge clk);
        r = $random(seed);
        cpu_flags <= r[3:0];
        prog_events <= r[7:4] | 4'h1;
        cpu_flags_update <= 1;
        security_active_flag <= 1;
        program_counter <= r[17:8];
        data_out_load <= 1;
        data_out_value <= r[31:16];
        m_flags = r[3:0];
        m_ev = r[7:4] | 4'h1;
        @(posedge clk);
        {cpu_flags_update, data_out_load, prog_events} <= '0;
        hr(6'h01);
        chk("rd_status", {1'b1, 4'h0, exp_stat()}, {rd_oe, rd_v});
        hr(6'h02);
        chk("rd_pc", r[17:8], rd_v);
        hr(6'h00);
        chk("rd_dout", r[31:16], rd_v);
        hr(6'h21);
        chk("no_drive", 0, rd_oe);
        hr(6'h03);
        {m_flags, m_ev, m_exc} = '0;
        chk("clear", exp_stat(), host_status_flags);
        wr(0);
        wr(0);
        hr(6'h04);
        q.delete();
        chk("flush", 2'b01, {fifo_output_ready, fifo_input_ready});
        @(posedge clk);
        standalone_mode <= 1;
        @(negedge clk);
        wr(0);
        chk("alone", 0, fifo_output_ready);
        close_out();
    end
endmodule // tb
